// ### design/spm_fifo.v
// Synchronous FIFO with valid/ready on both sides.
// Assumes a single clock domain and asynchronous active-low reset.
`timescale 1ns/100ps
module spm_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk_sys_i,
  input wire reset_n_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;
  assign in_ready_o = (cnt_q != DEPTH);
  assign out_valid_o = (cnt_q != 0);
  assign out_data_o = mem[rd_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  always @(posedge clk_sys_i) begin
    if (push) begin
      mem[wr_q] <= in_data_i;
    end
  end
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH-1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH-1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// ### design/spm_map.vh
// Constants for the SPI port pin multiplexer: line indices, reset values, timing.
// Assumes nothing of its surroundings; definitions only.
`ifndef SPM_MAP_VH
`define SPM_MAP_VH
// Pad indices within the four-line group
`define SPM_LINE_MISO 2'd0
`define SPM_LINE_MOSI 2'd1
`define SPM_LINE_SCLK 2'd2
`define SPM_LINE_SS 2'd3
// Function select: 0 selects the serial port
`define SPM_FSEL_RESET 4'h0
`define SPM_GPIO_DIR_RESET 4'h0
`define SPM_GPIO_OUT_RESET 4'h0
// Default serial clock half period in system clocks
`define SPM_HALF_PERIOD_DEF 8
`define SPM_WORD_BITS 8
`define SPM_FIFO_DEPTH 16
`endif

// ### design/spm_port.v
// SPI port with per-line GPIO sharing on four pads.
// Assumes pads are resolved outside: each pad gives input, output, active-low enable.
`timescale 1ns/100ps
`include "spm_map.vh"
module spm_port #(
  parameter WIDTH = `SPM_WORD_BITS,
  parameter DEPTH = `SPM_FIFO_DEPTH,
  parameter HALF = `SPM_HALF_PERIOD_DEF
) (
  input wire clk_sys_i,
  input wire reset_n_i,
  input wire master_i,
  input wire [3:0] func_gpio_i,
  input wire [3:0] gpio_dir_out_i,
  input wire [3:0] gpio_out_i,
  output reg [3:0] gpio_in_o,
  input wire shared_io_line_six_i,
  output reg shared_io_line_six_o,
  output reg shared_io_line_six_oe_n_o,
  input wire shared_io_line_five_i,
  output reg shared_io_line_five_o,
  output reg shared_io_line_five_oe_n_o,
  input wire shared_io_line_four_i,
  output reg shared_io_line_four_o,
  output reg shared_io_line_four_oe_n_o,
  input wire shared_io_line_seven_i,
  output reg shared_io_line_seven_o,
  output reg shared_io_line_seven_oe_n_o,
  input wire tx_valid_i,
  output wire tx_ready_o,
  input wire [WIDTH-1:0] tx_data_i,
  output reg rx_valid_o,
  output reg [WIDTH-1:0] rx_data_o,
  output reg mode_fault_o,
  output reg busy_o
);
  localparam ST_IDLE = 3'b001;
  localparam ST_LOW = 3'b010;
  localparam ST_HIGH = 3'b100;
  localparam [7:0] HALF_C = HALF;
  localparam [3:0] LAST_BIT = WIDTH - 1;

  // Two-stage synchronisers on all pad inputs
  reg [3:0] s1_q;
  reg [3:0] s2_q;
  reg s3_clk_q;
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s1_q <= 4'hf;
      s2_q <= 4'hf;
      // Matches the synchroniser's reset level so no false edge follows reset
      s3_clk_q <= 1'b1;
    end else begin
      s1_q <= {shared_io_line_seven_i, shared_io_line_four_i, shared_io_line_five_i, shared_io_line_six_i};
      s2_q <= s1_q;
      s3_clk_q <= s2_q[`SPM_LINE_SCLK];
    end
  end
  wire miso_s = s2_q[`SPM_LINE_MISO];
  wire mosi_s = s2_q[`SPM_LINE_MOSI];
  wire sclk_s = s2_q[`SPM_LINE_SCLK];
  wire ss_n_s = s2_q[`SPM_LINE_SS];
  wire sclk_rise = sclk_s && !s3_clk_q;
  wire sclk_fall = !sclk_s && s3_clk_q;
  wire [3:0] fsel = func_gpio_i;
  wire sel_slave = !master_i && !ss_n_s && !fsel[`SPM_LINE_SS];

  // Transmit FIFO: its ready stalls the source when the shifter lags
  wire f_valid;
  wire [WIDTH-1:0] f_data;
  reg f_pop;
  spm_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(4)) u_fifo (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .in_valid_i(tx_valid_i),
    .in_ready_o(tx_ready_o),
    .in_data_i(tx_data_i),
    .out_valid_o(f_valid),
    .out_ready_i(f_pop),
    .out_data_o(f_data)
  );

  reg [2:0] st_q;
  reg [7:0] div_q;
  reg [3:0] bit_q;
  reg [WIDTH-1:0] sh_q;
  reg [WIDTH-1:0] rsh_q;
  reg sclk_q;
  reg in_slave_q;
  wire fault = master_i && !ss_n_s && !fsel[`SPM_LINE_SS];
  wire master_bit = sh_q[WIDTH-1];

  always @* begin
    f_pop = 1'b0;
    if (master_i && st_q == ST_IDLE && !fault) begin
      f_pop = f_valid;
    end else if (sel_slave && !in_slave_q) begin
      f_pop = f_valid;
    end
  end

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_q <= ST_IDLE;
      div_q <= 8'h00;
      bit_q <= 4'h0;
      sh_q <= {WIDTH{1'b0}};
      rsh_q <= {WIDTH{1'b0}};
      sclk_q <= 1'b0;
      in_slave_q <= 1'b0;
      rx_valid_o <= 1'b0;
      rx_data_o <= {WIDTH{1'b0}};
      mode_fault_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      rx_valid_o <= 1'b0;
      mode_fault_o <= fault;
      if (master_i) begin
        in_slave_q <= 1'b0;
        case (st_q)
          ST_IDLE: begin
            sclk_q <= 1'b0;
            if (f_pop) begin
              // Data is set up now; first rise follows one half period later
              sh_q <= f_data;
              bit_q <= 4'h0;
              div_q <= HALF_C - 8'h01;
              st_q <= ST_LOW;
              busy_o <= 1'b1;
            end
          end
          ST_LOW: begin
            if (fault) begin
              st_q <= ST_IDLE;
              busy_o <= 1'b0;
            end else if (div_q == 8'h00) begin
              sclk_q <= 1'b1;
              rsh_q <= {rsh_q[WIDTH-2:0], miso_s};
              div_q <= HALF_C - 8'h01;
              st_q <= ST_HIGH;
            end else begin
              div_q <= div_q - 8'h01;
            end
          end
          ST_HIGH: begin
            if (fault) begin
              sclk_q <= 1'b0;
              st_q <= ST_IDLE;
              busy_o <= 1'b0;
            end else if (div_q == 8'h00) begin
              sclk_q <= 1'b0;
              div_q <= HALF_C - 8'h01;
              if (bit_q == LAST_BIT) begin
                rx_data_o <= rsh_q;
                rx_valid_o <= 1'b1;
                st_q <= ST_IDLE;
                busy_o <= 1'b0;
              end else begin
                // Shift on falling edge: next bit leads the next rise by half a period
                sh_q <= {sh_q[WIDTH-2:0], 1'b0};
                bit_q <= bit_q + 4'h1;
                st_q <= ST_LOW;
              end
            end else begin
              div_q <= div_q - 8'h01;
            end
          end
          default: begin
            st_q <= ST_IDLE;
          end
        endcase
      end else begin
        st_q <= ST_IDLE;
        sclk_q <= 1'b0;
        busy_o <= sel_slave;
        in_slave_q <= sel_slave;
        if (!sel_slave) begin
          // Deselect aborts any partial word
          bit_q <= 4'h0;
        end else begin
          if (!in_slave_q) begin
            sh_q <= f_valid ? f_data : {WIDTH{1'b0}};
            bit_q <= 4'h0;
          end
          if (sclk_rise) begin
            rsh_q <= {rsh_q[WIDTH-2:0], mosi_s};
            if (bit_q == LAST_BIT) begin
              rx_data_o <= {rsh_q[WIDTH-2:0], mosi_s};
              rx_valid_o <= 1'b1;
              bit_q <= 4'h0;
            end else begin
              bit_q <= bit_q + 4'h1;
            end
          end
          if (sclk_fall) begin
            if (bit_q == 4'h0 && f_valid && in_slave_q) begin
              sh_q <= f_data;
            end else begin
              sh_q <= {sh_q[WIDTH-2:0], 1'b0};
            end
          end
        end
      end
    end
  end

  // Pad drive: port values and enables before the GPIO override
  reg [3:0] pout;
  reg [3:0] poe;
  always @* begin
    pout = 4'h0;
    poe = 4'h0;
    pout[`SPM_LINE_MISO] = master_bit;
    poe[`SPM_LINE_MISO] = sel_slave;
    pout[`SPM_LINE_MOSI] = master_bit;
    poe[`SPM_LINE_MOSI] = master_i;
    pout[`SPM_LINE_SCLK] = sclk_q;
    poe[`SPM_LINE_SCLK] = master_i;
    if (fsel[`SPM_LINE_MISO] == 1'b0 && master_i) begin
      poe[`SPM_LINE_MISO] = 1'b0;
    end
  end
  reg [3:0] dout;
  reg [3:0] den;
  always @* begin
    dout = 4'h0;
    den = 4'h0;
    // GPIO owns a line whose select bit is set
    dout = (fsel & gpio_out_i) | (~fsel & pout);
    den = (fsel & gpio_dir_out_i) | (~fsel & poe);
  end

  // Registered pad outputs; reset leaves every driver off
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      shared_io_line_six_o <= 1'b0;
      shared_io_line_five_o <= 1'b0;
      shared_io_line_four_o <= 1'b0;
      shared_io_line_seven_o <= 1'b0;
      shared_io_line_six_oe_n_o <= 1'b1;
      shared_io_line_five_oe_n_o <= 1'b1;
      shared_io_line_four_oe_n_o <= 1'b1;
      shared_io_line_seven_oe_n_o <= 1'b1;
      gpio_in_o <= 4'h0;
    end else begin
      shared_io_line_six_o <= dout[0];
      shared_io_line_five_o <= dout[1];
      shared_io_line_four_o <= dout[2];
      shared_io_line_seven_o <= dout[3];
      shared_io_line_six_oe_n_o <= !den[0];
      shared_io_line_five_oe_n_o <= !den[1];
      shared_io_line_four_oe_n_o <= !den[2];
      shared_io_line_seven_oe_n_o <= !den[3];
      gpio_in_o <= s2_q & fsel;
    end
  end
  // Select lines come in as plain inputs reset to serial function by the owner
  // func_gpio_i low means serial port; owner resets it to `SPM_FSEL_RESET
endmodule

// ### tb/spm_checker.sv
// Port assertions for the SPI pin multiplexer.
// Assumes binding into spm_port; pad inputs pass a two-flop synchroniser.
`timescale 1ns/100ps
module spm_checker (
  input wire clk_sys_i,
  input wire reset_n_i,
  input wire master_i,
  input wire [3:0] func_gpio_i,
  input wire [3:0] gpio_dir_out_i,
  input wire [3:0] gpio_out_i,
  input wire shared_io_line_six_oe_n_o,
  input wire shared_io_line_five_oe_n_o,
  input wire shared_io_line_five_o,
  input wire shared_io_line_four_oe_n_o,
  input wire shared_io_line_seven_i,
  input wire mode_fault_o,
  input wire busy_o,
  input wire rx_valid_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  // Five cycles of a steady pad cover the synchroniser and the output register
  wire sel_hi = !func_gpio_i[3] && shared_io_line_seven_i;
  wire six_in = shared_io_line_six_oe_n_o;
  a_rst_drv_off: assert property (
    $rose(reset_n_i) |-> six_in && shared_io_line_five_oe_n_o && shared_io_line_four_oe_n_o)
    else $error("pad driven at reset release");
  a_master_miso_in: assert property (
    master_i && !func_gpio_i[0] |=> six_in) else $error("data-in pad driven as master");
  a_slave_mosi_in: assert property (
    !master_i && !func_gpio_i[1] |=> shared_io_line_five_oe_n_o) else $error("data-out pad driven as slave");
  a_slave_clk_in: assert property (
    !master_i && !func_gpio_i[2] |=> shared_io_line_four_oe_n_o) else $error("clock pad driven as slave");
  a_unsel_hiz: assert property (
    (!master_i && !func_gpio_i[0] && sel_hi) [*5] |-> six_in) else $error("data-in pad driven unselected");
  a_slave_quiet: assert property (
    (!master_i && sel_hi) [*5] |-> !busy_o && !rx_valid_o) else $error("slave active unselected");
  a_fault_raise: assert property (
    (master_i && !func_gpio_i[3] && !shared_io_line_seven_i) [*5] |-> mode_fault_o && !busy_o)
    else $error("no fault on low select");
  a_fault_cause: assert property (
    $rose(mode_fault_o) |-> master_i && !func_gpio_i[3]) else $error("fault without cause");
  a_gpio_dir: assert property (
    func_gpio_i[1] |=> shared_io_line_five_oe_n_o == !$past(gpio_dir_out_i[1])) else $error("gpio direction");
  a_gpio_value: assert property (
    func_gpio_i[1] && gpio_dir_out_i[1] |=> shared_io_line_five_o == $past(gpio_out_i[1]))
    else $error("gpio value");
  c_master_word: cover property (master_i && rx_valid_o);
  c_slave_word: cover property (!master_i && rx_valid_o);
  c_fault: cover property (mode_fault_o);
endmodule
bind spm_port spm_checker spm_checker_inst (.*);

// ### tb/spm_far_end.sv
// Far-end SPI party: slave while the device leads, master while it follows.
// Assumes mode 0, MSB first; the bench resolves pads with pull-ups.
`timescale 1ns/100ps
module spm_far_end (
  input wire lead_i,
  input wire clr_i,
  input wire go_i,
  input wire sel_i,
  input wire [7:0] tx_byte_i,
  input wire sclk_i,
  input wire din_i,
  output wire data_o,
  output reg sclk_o,
  output reg ss_n_o,
  output reg [7:0] rx_byte_o
);
  reg [7:0] tsh_q;
  reg [7:0] rsh_q;
  reg [2:0] idx_q;
  integer i;
  // One shifter for both roles: next bit on the fall, capture on the rise
  assign data_o = tsh_q[~idx_q];
  always @(posedge sclk_i) begin
    rsh_q <= {rsh_q[6:0], din_i};
  end
  always @(negedge sclk_i or posedge clr_i) begin
    if (clr_i) begin
      idx_q <= 3'h0;
      tsh_q <= tx_byte_i;
    end else begin
      idx_q <= idx_q + 3'h1;
      if (idx_q == 3'h7) begin
        tsh_q <= tx_byte_i;
        rx_byte_o <= rsh_q;
      end
    end
  end
  initial begin
    sclk_o = 1'b0;
    ss_n_o = 1'b1;
  end
  // Clock runs only inside a frame, 64 ns period
  always @(posedge go_i) begin
    ss_n_o = !sel_i;
    #32;
    for (i = 0; i < 8; i = i + 1) begin
      sclk_o = 1'b1;
      #32;
      sclk_o = 1'b0;
      #32;
    end
    ss_n_o = 1'b1;
  end
endmodule

// ### tb/testbench.sv
// Self-checking bench for the SPI port pin multiplexer and its GPIO sharing.
// Assumes spm_port, spm_far_end and the bound checker; pads have pull-ups.
`timescale 1ns/100ps
module testbench;
  localparam int HALF = 8;
  logic clk_sys_i, reset_n_i, master_i, tx_valid_i, far_on, lead, clr, go, sel;
  logic [3:0] func_gpio_i, gpio_dir_out_i, gpio_out_i, ext_v;
  logic [7:0] tx_data_i, far_tx;
  logic [31:0] seed = 32'h124187eb;
  wire [3:0] gpio_in_o, pin_o, oe_n, pad, far_en;
  wire [7:0] rx_data_o, far_rx;
  wire tx_ready_o, rx_valid_o, mode_fault_o, busy_o, far_d, far_sclk, far_ss_n;
  int fail_count, checks, rx_n, rx0, k;
  logic [7:0] sent_q[$], far_q[$];
  assign far_en = far_on ? {lead, lead, lead, !lead} : 4'h0;
  assign pad = (~oe_n & pin_o) | (oe_n & far_en & {far_ss_n, far_sclk, far_d, far_d}) | (oe_n & ~far_en & ext_v);
  spm_port #(.HALF(HALF)) spm_port_inst (
    .clk_sys_i, .reset_n_i, .master_i, .func_gpio_i, .gpio_dir_out_i, .gpio_out_i, .gpio_in_o,
    .shared_io_line_six_i(pad[0]), .shared_io_line_six_o(pin_o[0]), .shared_io_line_six_oe_n_o(oe_n[0]),
    .shared_io_line_five_i(pad[1]), .shared_io_line_five_o(pin_o[1]), .shared_io_line_five_oe_n_o(oe_n[1]),
    .shared_io_line_four_i(pad[2]), .shared_io_line_four_o(pin_o[2]), .shared_io_line_four_oe_n_o(oe_n[2]),
    .shared_io_line_seven_i(pad[3]), .shared_io_line_seven_o(pin_o[3]), .shared_io_line_seven_oe_n_o(oe_n[3]),
    .tx_valid_i, .tx_ready_o, .tx_data_i, .rx_valid_o, .rx_data_o, .mode_fault_o, .busy_o);
  spm_far_end spm_far_end_inst (.lead_i(lead), .clr_i(clr), .go_i(go), .sel_i(sel), .tx_byte_i(far_tx),
    .sclk_i(pad[2]), .din_i(lead ? pad[0] : pad[1]), .data_o(far_d), .sclk_o(far_sclk), .ss_n_o(far_ss_n),
    .rx_byte_o(far_rx));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic restart_far();
    clr = 1'b1;
    #1 clr = 1'b0;
  endtask
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  // Tests need about 3300 cycles; fifteen times that means a hang
  initial begin
    #200000;
    fail_count++;
    conclude();
  end
  always @(posedge clk_sys_i) begin
    if (rx_valid_o === 1'b1) begin
      rx_n++;
      check(rx_data_o, far_tx);
    end
  end
  always @(negedge pad[2]) begin
    #1;
    if (far_on && !lead && spm_far_end_inst.idx_q == 3'h0)
      far_q.push_back(far_rx);
  end
  initial begin
    {reset_n_i, master_i, tx_valid_i, far_on, lead, clr, go, sel} = '0;
    {func_gpio_i, gpio_dir_out_i, gpio_out_i, tx_data_i, far_tx} = '0;
    ext_v = 4'hf;
    repeat (8) @(posedge clk_sys_i);
    check(oe_n, 4'hf);
    reset_n_i <= 1'b1;
    master_i <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    check(oe_n[2:0], 3'b001);
    far_on = 1'b1;
    far_tx = 8'(rnd());
    restart_far();
    // Twenty words back to back overrun the FIFO, so refusals occur
    k = 0;
    tx_data_i <= 8'(rnd());
    tx_valid_i <= 1'b1;
    while (k < 20) begin
      @(posedge clk_sys_i);
      if (tx_ready_o === 1'b1) begin
        sent_q.push_back(tx_data_i);
        k++;
        tx_data_i <= 8'(rnd());
      end
      tx_valid_i <= k < 20;
    end
    for (k = 0; k < 4000 && rx_n < 20; k++) @(posedge clk_sys_i);
    // The far end logs its last word on the pad's falling clock, a cycle after the pulse
    repeat (4) @(posedge clk_sys_i);
    check(8'(far_q.size()), 8'd20);
    foreach (sent_q[j]) check(far_q[j], sent_q[j]);
    $display("master test done");
    ext_v[3] <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
    check({mode_fault_o, busy_o}, 2'b10);
    ext_v[3] <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    check(mode_fault_o, 1'b0);
    $display("fault test done");
    master_i <= 1'b0;
    lead = 1'b1;
    rx0 = rx_n;
    repeat (8) @(posedge clk_sys_i);
    check(oe_n[2:0], 3'b111);
    for (k = 0; k < 4; k++) begin
      sel = k != 2;
      far_tx = 8'(rnd());
      restart_far();
      #1.7 go = 1'b1;
      #1 go = 1'b0;
      #100;
      check(oe_n[0], !sel);
      #500;
      // Transmit FIFO is drained by now, so a selected slave shifts out zeros
      if (sel) check(far_rx, 8'h00);
      repeat (8) @(posedge clk_sys_i);
    end
    check(8'(rx_n - rx0), 8'd3);
    $display("slave test done");
    far_on <= 1'b0;
    func_gpio_i <= 4'hf;
    for (k = 0; k < 8; k++) begin
      gpio_dir_out_i <= 4'(rnd());
      gpio_out_i <= 4'(rnd());
      ext_v <= 4'(rnd());
      repeat (6) @(posedge clk_sys_i);
      check(oe_n, 4'(~gpio_dir_out_i));
      check(gpio_in_o, 4'((gpio_dir_out_i & gpio_out_i) | (~gpio_dir_out_i & ext_v)));
    end
    $display("gpio test done");
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    check(oe_n, 4'hf);
    $display("reset test done");
    conclude();
  end
endmodule
